/* File: csp_pkg.sv */
// Constants, state type and code decoders for the card status fields
// Assumes a single 40 MHz core clock and synchronous active-high reset
package csp_pkg;

   // Field widths
   localparam int AU_W = 10;
   localparam int SUSP_W = 22;
   localparam int CLASS_W = 4;
   localparam int DEPTH_W = 5;
   localparam int SU_W = 4;
   localparam int TASK_W = 32;
   localparam int CMD_IDX_W = 6;
   localparam int CAP_W = 32;

   // Command decode
   localparam logic [5:0] CMD_STATUS = 6'h0D;
   localparam logic [5:0] CMD_VIDEO = 6'h14;
   localparam int ARG_TASK_BIT = 15;
   localparam int VSC_FUNC_HI = 31;
   localparam int VSC_FUNC_LO = 28;
   localparam logic [3:0] VSC_SUSPEND = 4'h5;
   localparam logic [3:0] VSC_SET_FREE = 4'h7;

   // Video allocation unit codes and recording subunit sizes in MB
   localparam logic [9:0] AU_NONE = 10'h000;
   localparam logic [3:0] SU_NONE = 4'h0;
   localparam logic [3:0] SU_7MB = 4'h7;
   localparam logic [3:0] SU_8MB = 4'h8;
   localparam logic [3:0] SU_9MB = 4'h9;
   localparam logic [3:0] SU_10MB = 4'hA;
   localparam logic [31:0] MIN_UNITS_HC = 32'h0000_0028;
   localparam logic [31:0] MIN_UNITS_XC = 32'h0000_0050;
   localparam logic [21:0] SUSP_NONE = 22'h00_0000;

   // Application class codes
   localparam logic [3:0] CLASS_NONE = 4'h0;
   localparam logic [3:0] CLASS_ONE = 4'h1;
   localparam logic [3:0] CLASS_TWO = 4'h2;

   // Bit positions inside the 8-bit feature byte
   localparam int PERF_CARD_MAINT = 0;
   localparam int PERF_HOST_MAINT = 1;
   localparam int PERF_CACHE = 2;
   localparam int PERF_DEPTH_LO = 3;
   localparam logic [7:0] PERF_RESET = 8'h00;
   localparam logic [31:0] TASK_MAP_RESET = 32'h0000_0000;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      CSP_SUSP_IDLE = 2'b01,
      CSP_SUSP_HELD = 2'b10
   } csp_susp_t;

   function automatic logic csp_au_valid(input logic [9:0] c);
      case (c)
         10'h008, 10'h010, 10'h015, 10'h018, 10'h01B, 10'h01C,
         10'h01E, 10'h020, 10'h024, 10'h028, 10'h02A, 10'h02D,
         10'h030, 10'h036, 10'h038, 10'h03C, 10'h040, 10'h048,
         10'h050, 10'h060, 10'h070, 10'h078, 10'h080, 10'h090,
         10'h0A0, 10'h0C0, 10'h0D8, 10'h0E0, 10'h0F0, 10'h100,
         10'h120, 10'h140, 10'h180, 10'h1B0, 10'h1C0, 10'h1E0,
         10'h200: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : csp_au_valid

   function automatic logic [3:0] csp_au_subunit(input logic [9:0] c);
      if (!csp_au_valid(c)) begin
         return SU_NONE;
      end
      case (c)
         10'h015, 10'h01C, 10'h02A: return SU_7MB;
         10'h01B, 10'h024, 10'h02D, 10'h036: return SU_9MB;
         10'h01E, 10'h03C: return SU_10MB;
         default: return SU_8MB;
      endcase
   endfunction : csp_au_subunit

endpackage : csp_pkg

/* File: csp_au_check.sv */
// Checks a requested video allocation unit size against the code list
// and the card capacity; purely combinational
// Assumes capacity in MB and the capacity class are stable while loading
`timescale 1ns/10ps
module csp_au_check
   import csp_pkg::*;
(
   // Request
   input wire logic [AU_W-1:0] au_req,
   // Card geometry
   input wire logic [CAP_W-1:0] capacity_mb,
   input wire logic extended_cap,
   // Verdict
   output logic au_ok,
   output logic [SU_W-1:0] subunit_mb
);

   logic [31:0] min_units;
   logic [31:0] needed_mb;

   always_comb begin
      min_units = extended_cap ? MIN_UNITS_XC : MIN_UNITS_HC;
      needed_mb = 32'(au_req) * min_units;
      au_ok = csp_au_valid(au_req) && (needed_mb <= capacity_mb);
      subunit_mb = csp_au_subunit(au_req);
   end

endmodule : csp_au_check

/* File: csp_task_map.sv */
// Ready map of queued tasks, one bit per task
// Assumes set and clear pulses come from the task scheduler of the card
`timescale 1ns/10ps
module csp_task_map
   import csp_pkg::*;
#(
   parameter int NUM_TASKS = 32
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Task events
   input wire logic [TASK_W-1:0] ready_set,
   input wire logic [TASK_W-1:0] ready_clr,
   // Map
   output logic [TASK_W-1:0] ready_map
);

   localparam logic [TASK_W-1:0] USED_MASK =
      TASK_W'((64'h1 << NUM_TASKS) - 64'h1);

   logic [TASK_W-1:0] next_ready_map;

   always_comb begin
      // Set wins over clear; bits beyond the used tasks stay zero
      next_ready_map = ((ready_map & ~ready_clr) | ready_set) & USED_MASK;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ready_map <= TASK_MAP_RESET;
      end else if (clk_en) begin
         ready_map <= next_ready_map;
      end
   end

   a_map_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
      (ready_map & ~USED_MASK) == TASK_MAP_RESET)
      else $error("unused task bit set");

   a_task_set_wins: assert property (@(posedge core_clk) disable iff (rst)
      (clk_en && |(ready_set & USED_MASK)) |=>
      ((ready_map & $past(ready_set) & USED_MASK)
       == ($past(ready_set) & USED_MASK)))
      else $error("set task not ready");

endmodule : csp_task_map

/* File: csp_fields.sv */
// Card-side status fields: video allocation unit, suspension point,
// application class, feature byte and the queued task response
// Assumes commands arrive decoded as one-cycle strobes from the card
// command front end, and firmware strobes configuration loads
`timescale 1ns/10ps

module csp_fields
   import csp_pkg::*;
#(
   parameter int NUM_TASKS = 32
)
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Host command strobe
   input wire logic cmd_valid,
   input wire logic [CMD_IDX_W-1:0] cmd_index,
   input wire logic [31:0] cmd_arg,
   // Normal card status for the status command
   input wire logic [31:0] card_status,
   // Firmware configuration
   input wire logic cfg_load,
   input wire logic [AU_W-1:0] cfg_au_req,
   input wire logic [CAP_W-1:0] capacity_mb,
   input wire logic extended_cap,
   input wire logic [CLASS_W-1:0] cfg_app_class,
   input wire logic [CLASS_W-1:0] measured_class,
   input wire logic cache_support,
   input wire logic host_maint_support,
   input wire logic card_maint_support,
   input wire logic [DEPTH_W-1:0] queue_depth_code,
   // Recording position and memory traffic, 512 KB units
   input wire logic [SUSP_W-1:0] cur_point,
   input wire logic [SUSP_W-1:0] cur_au_base,
   input wire logic mem_write,
   input wire logic mem_erase,
   input wire logic [SUSP_W-1:0] mem_addr,
   // Task events
   input wire logic [TASK_W-1:0] task_ready_set,
   input wire logic [TASK_W-1:0] task_ready_clr,
   // Status block fields
   output logic [AU_W-1:0] video_class_au_size,
   output logic [SU_W-1:0] recording_subunit,
   output logic [SUSP_W-1:0] suspend_point,
   output logic [CLASS_W-1:0] app_class_level,
   output logic [7:0] perf_feature_flags,
   // Status command response
   output logic resp_valid,
   output logic resp_is_task,
   output logic [31:0] resp_data
);

   // Allocation unit check
   logic au_ok;
   logic [SU_W-1:0] req_subunit;

   csp_au_check u_au_check (
      .au_req(cfg_au_req),
      .capacity_mb(capacity_mb),
      .extended_cap(extended_cap),
      .au_ok(au_ok),
      .subunit_mb(req_subunit)
   );

   // Task ready map
   logic [TASK_W-1:0] queued_task_ready_map;

   csp_task_map #(.NUM_TASKS(NUM_TASKS)) u_task_map (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .ready_set(task_ready_set),
      .ready_clr(task_ready_clr),
      .ready_map(queued_task_ready_map)
   );

   // Command decode
   logic status_cmd;
   logic task_cmd;
   logic suspend_cmd;
   logic set_free_cmd;
   logic [3:0] vsc_func;

   always_comb begin
      vsc_func = cmd_arg[VSC_FUNC_HI:VSC_FUNC_LO];
      status_cmd = cmd_valid && (cmd_index == CMD_STATUS);
      task_cmd = status_cmd && cmd_arg[ARG_TASK_BIT];
      suspend_cmd = cmd_valid && (cmd_index == CMD_VIDEO)
                    && (vsc_func == VSC_SUSPEND);
      set_free_cmd = cmd_valid && (cmd_index == CMD_VIDEO)
                     && (vsc_func == VSC_SET_FREE);
   end

   // Video allocation unit and subunit
   logic [AU_W-1:0] next_au;
   logic [SU_W-1:0] next_su;

   always_comb begin
      next_au = video_class_au_size;
      next_su = recording_subunit;
      if (cfg_load) begin
         // Rejected requests report unsupported rather than a larger size
         next_au = au_ok ? cfg_au_req : AU_NONE;
         next_su = au_ok ? req_subunit : SU_NONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         video_class_au_size <= AU_NONE;
         recording_subunit <= SU_NONE;
      end else if (clk_en) begin
         video_class_au_size <= next_au;
         recording_subunit <= next_su;
      end
   end

   // Suspension point tracking
   csp_susp_t susp_state;
   csp_susp_t next_susp_state;
   logic [SUSP_W-1:0] susp_base;
   logic [SUSP_W-1:0] next_susp_point;
   logic [SUSP_W-1:0] next_susp_base;
   logic [SUSP_W-1:0] au_len;
   logic [SUSP_W:0] au_end;
   logic mem_hit;

   always_comb begin
      // Two 512 KB units per MB
      au_len = SUSP_W'({video_class_au_size, 1'b0});
      au_end = {1'b0, susp_base} + {1'b0, au_len};
      mem_hit = (mem_write || mem_erase)
                && (mem_addr >= susp_base)
                && ({1'b0, mem_addr} < au_end);
      next_susp_state = susp_state;
      next_susp_point = suspend_point;
      next_susp_base = susp_base;
      case (susp_state)
         CSP_SUSP_IDLE: begin
            if (suspend_cmd && (cur_point != SUSP_NONE)) begin
               next_susp_state = CSP_SUSP_HELD;
               next_susp_point = cur_point;
               next_susp_base = cur_au_base;
            end
         end
         CSP_SUSP_HELD: begin
            // A new suspend in the same cycle wins over a clear
            if (suspend_cmd && (cur_point != SUSP_NONE)) begin
               next_susp_point = cur_point;
               next_susp_base = cur_au_base;
            end else if (set_free_cmd || mem_hit) begin
               next_susp_state = CSP_SUSP_IDLE;
               next_susp_point = SUSP_NONE;
            end
         end
         default: begin
            next_susp_state = CSP_SUSP_IDLE;
            next_susp_point = SUSP_NONE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         susp_state <= CSP_SUSP_IDLE;
         suspend_point <= SUSP_NONE;
         susp_base <= SUSP_NONE;
      end else if (clk_en) begin
         susp_state <= next_susp_state;
         suspend_point <= next_susp_point;
         susp_base <= next_susp_base;
      end
   end

   // Application class and feature byte
   logic [CLASS_W-1:0] next_class;
   logic [CLASS_W-1:0] class_min;
   logic [7:0] next_perf;

   always_comb begin
      class_min = (cfg_app_class < measured_class)
                  ? cfg_app_class : measured_class;
      // Reserved codes are never emitted
      next_class = (class_min > CLASS_TWO) ? CLASS_TWO : class_min;
      next_perf = PERF_RESET;
      next_perf[7:PERF_DEPTH_LO] = queue_depth_code;
      next_perf[PERF_CACHE] = cache_support;
      next_perf[PERF_HOST_MAINT] = host_maint_support;
      next_perf[PERF_CARD_MAINT] = card_maint_support;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         app_class_level <= CLASS_NONE;
         perf_feature_flags <= PERF_RESET;
      end else if (clk_en) begin
         app_class_level <= next_class;
         perf_feature_flags <= next_perf;
      end
   end

   // Status command response
   logic next_resp_valid;
   logic next_resp_is_task;
   logic [31:0] next_resp_data;

   always_comb begin
      next_resp_valid = status_cmd;
      next_resp_is_task = task_cmd;
      next_resp_data = resp_data;
      if (status_cmd) begin
         next_resp_data = task_cmd ? queued_task_ready_map
                                   : card_status;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp_is_task <= 1'b0;
         resp_data <= STATUS_RESET;
      end else if (clk_en) begin
         resp_valid <= next_resp_valid;
         resp_is_task <= next_resp_is_task;
         resp_data <= next_resp_data;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_au_code_legal: assert property (
      (video_class_au_size == AU_NONE)
      || csp_au_valid(video_class_au_size))
      else $error("reserved allocation unit code");

   a_au_unit_count: assert property (
      (clk_en && cfg_load) |=> (video_class_au_size == AU_NONE)
      || ((32'(video_class_au_size)
           * ($past(extended_cap) ? MIN_UNITS_XC : MIN_UNITS_HC))
          <= $past(capacity_mb)))
      else $error("too few allocation units");

   a_su_mapping: assert property (
      recording_subunit == csp_au_subunit(video_class_au_size))
      else $error("subunit does not match size");

   a_suspend_load: assert property (
      (clk_en && suspend_cmd && (cur_point != SUSP_NONE))
      |=> (suspend_point == $past(cur_point))
          && (susp_state == CSP_SUSP_HELD))
      else $error("suspension point not loaded");

   a_suspend_clear: assert property (
      (clk_en && !suspend_cmd && (set_free_cmd || mem_hit))
      |=> (suspend_point == SUSP_NONE))
      else $error("suspension point not cleared");

   a_suspend_state: assert property (
      (suspend_point == SUSP_NONE) == (susp_state == CSP_SUSP_IDLE))
      else $error("suspension point and state disagree");

   a_class_capped: assert property (
      (clk_en ##1 1'b1) |-> (app_class_level <= CLASS_TWO)
      && (app_class_level <= $past(measured_class)))
      else $error("class above measured or reserved");

   a_perf_layout: assert property (
      (clk_en && !rst) |=> perf_feature_flags == {$past(queue_depth_code),
         $past(cache_support), $past(host_maint_support),
         $past(card_maint_support)})
      else $error("feature byte layout wrong");

   a_task_response: assert property (
      (clk_en && task_cmd) |=> resp_valid && resp_is_task
      && (resp_data == $past(queued_task_ready_map)))
      else $error("task map not returned");

   a_plain_status: assert property (
      (clk_en && status_cmd && !task_cmd) |=> resp_valid && !resp_is_task
      && (resp_data == $past(card_status)))
      else $error("card status not returned");

   a_freeze: assert property (
      !clk_en |=> $stable(suspend_point) && $stable(video_class_au_size))
      else $error("state moved while disabled");

   c_suspend_then_free: cover property (
      (clk_en && suspend_cmd) ##[1:20] (clk_en && set_free_cmd));
   c_write_hit: cover property (clk_en && mem_hit
      && (susp_state == CSP_SUSP_HELD));
   c_task_resp: cover property (clk_en && task_cmd);
   c_au_reject: cover property (clk_en && cfg_load && !au_ok);

endmodule : csp_fields

/* File: csp_host_model.sv */
// Host controller model that issues card commands and takes responses
// Assumes responses arrive registered, on the taking edge itself
`timescale 1ns/10ps
module csp_host_model
   import csp_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Command side
   output logic cmd_valid,
   output logic [CMD_IDX_W-1:0] cmd_index,
   output logic [31:0] cmd_arg,
   // Response side
   input wire logic resp_valid,
   input wire logic resp_is_task,
   input wire logic [31:0] resp_data,
   // Class view of the host
   input wire logic [CLASS_W-1:0] app_class_level,
   output logic class_one_ok
);
   initial begin
      cmd_valid = 1'b0;
      cmd_index = 6'h00;
      cmd_arg = 32'h0000_0000;
   end

   // Class one or any higher code counts as class one support
   assign class_one_ok = (app_class_level >= CLASS_ONE);

   // One-cycle command strobe; argument scrambled once released
   task automatic issue(input logic [5:0] idx, input logic [31:0] arg);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_index <= idx;
      cmd_arg <= arg;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      cmd_arg <= ~arg;
   endtask : issue

   // Status command; bit 15 of the argument asks for the task map
   task automatic status(input logic [31:0] arg, output logic seen,
                         output logic is_task, output logic [31:0] data);
      issue(CMD_STATUS, arg);
      #1;
      seen = resp_valid;
      is_task = resp_is_task;
      data = resp_data;
   endtask : status
endmodule : csp_host_model

/* File: tb_top.sv */
// Self-checking bench for the card status fields
// Assumes the host model drives commands; the bench drives the rest
`timescale 1ns/10ps
module tb_top
   import csp_pkg::*;
;
   typedef struct packed {
      logic [9:0] au;
      logic [31:0] cap;
      logic ext;
      logic [3:0] cls;
      logic [3:0] meas;
      logic [7:0] feat;
      logic [9:0] x_au;
      logic [3:0] x_su;
      logic [3:0] x_cls;
   } csp_row_t;

   logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, cfg_load = 1'b0;
   logic cmd_valid, resp_valid, resp_is_task, class_one_ok;
   logic [5:0] cmd_index;
   logic [31:0] cmd_arg, resp_data, capacity_mb = 32'h0;
   logic [31:0] card_status = 32'hA5A5_5A5A;
   logic [9:0] cfg_au_req = 10'h000, video_class_au_size;
   logic extended_cap = 1'b0, mem_write = 1'b0, mem_erase = 1'b0;
   logic [3:0] cfg_app_class = 4'h0, measured_class = 4'h0;
   logic [3:0] recording_subunit, app_class_level;
   logic [7:0] feat = 8'h00, perf_feature_flags;
   logic [21:0] cur_point = 22'h0, cur_au_base = 22'h0, mem_addr = 22'h0;
   logic [21:0] suspend_point;
   logic [31:0] ready_set = 32'h0, ready_clr = 32'h0;
   logic seen, is_task;
   logic [31:0] data;
   int bad_count = 0;
   int tests_run = 0;
   csp_row_t rows [10] = '{
      '{10'h015, 32'h0001_0000, 1'b0, 4'h1, 4'h2, 8'hFD, 10'h015, 4'h7, 4'h1},
      '{10'h01B, 32'h0001_0000, 1'b1, 4'h2, 4'h2, 8'h02, 10'h01B, 4'h9, 4'h2},
      '{10'h01E, 32'h0001_0000, 1'b0, 4'hF, 4'hF, 8'h00, 10'h01E, 4'hA, 4'h2},
      '{10'h008, 32'h0001_0000, 1'b0, 4'h2, 4'h1, 8'h05, 10'h008, 4'h8, 4'h1},
      '{10'h200, 32'h0000_A000, 1'b1, 4'h0, 4'h2, 8'hF8, 10'h200, 4'h8, 4'h0},
      '{10'h200, 32'h0000_9FFF, 1'b1, 4'h1, 4'h0, 8'h0B, 10'h000, 4'h0, 4'h0},
      '{10'h060, 32'h0000_0F00, 1'b0, 4'h3, 4'h3, 8'h04, 10'h060, 4'h8, 4'h2},
      '{10'h060, 32'h0000_0EFF, 1'b0, 4'hF, 4'h1, 8'h01, 10'h000, 4'h0, 4'h1},
      '{10'h009, 32'h0001_0000, 1'b0, 4'h1, 4'h1, 8'h08, 10'h000, 4'h0, 4'h1},
      '{10'h3FF, 32'h0001_0000, 1'b1, 4'h2, 4'h2, 8'h10, 10'h000, 4'h0, 4'h2}
   };

   csp_fields #(.NUM_TASKS(24)) uut (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
      .card_status(card_status), .cfg_load(cfg_load),
      .cfg_au_req(cfg_au_req), .capacity_mb(capacity_mb),
      .extended_cap(extended_cap), .cfg_app_class(cfg_app_class),
      .measured_class(measured_class), .cache_support(feat[2]),
      .host_maint_support(feat[1]), .card_maint_support(feat[0]),
      .queue_depth_code(feat[7:3]), .cur_point(cur_point),
      .cur_au_base(cur_au_base), .mem_write(mem_write),
      .mem_erase(mem_erase), .mem_addr(mem_addr),
      .task_ready_set(ready_set), .task_ready_clr(ready_clr),
      .video_class_au_size(video_class_au_size),
      .recording_subunit(recording_subunit), .suspend_point(suspend_point),
      .app_class_level(app_class_level),
      .perf_feature_flags(perf_feature_flags), .resp_valid(resp_valid),
      .resp_is_task(resp_is_task), .resp_data(resp_data));

   csp_host_model host (
      .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
      .cmd_arg(cmd_arg), .resp_valid(resp_valid),
      .resp_is_task(resp_is_task), .resp_data(resp_data),
      .app_class_level(app_class_level), .class_one_ok(class_one_ok));

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   // Memory write or erase pulse, settled output sampled after the edge
   task automatic mem_op(input logic wr, input logic er,
                         input logic [21:0] a);
      @(posedge core_clk);
      mem_write <= wr;
      mem_erase <= er;
      mem_addr <= a;
      @(posedge core_clk);
      mem_write <= 1'b0;
      mem_erase <= 1'b0;
      #1;
   endtask : mem_op

   task automatic load_au(input logic [9:0] au);
      @(posedge core_clk);
      cfg_load <= 1'b1;
      cfg_au_req <= au;
      @(posedge core_clk);
      cfg_load <= 1'b0;
      #1;
   endtask : load_au

   task automatic task_ev(input logic [31:0] s, input logic [31:0] c);
      @(posedge core_clk);
      ready_set <= s;
      ready_clr <= c;
      @(posedge core_clk);
      ready_set <= 32'h0;
      ready_clr <= 32'h0;
   endtask : task_ev

   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      conclude();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk(video_class_au_size, 10'h000);
      chk(suspend_point, 22'h0);
      chk(resp_valid, 1'b0);
      foreach (rows[i]) begin
         @(posedge core_clk);
         cfg_load <= 1'b1;
         cfg_au_req <= rows[i].au;
         capacity_mb <= rows[i].cap;
         extended_cap <= rows[i].ext;
         cfg_app_class <= rows[i].cls;
         measured_class <= rows[i].meas;
         feat <= rows[i].feat;
         @(posedge core_clk);
         cfg_load <= 1'b0;
         #1;
         chk(video_class_au_size, rows[i].x_au);
         chk(recording_subunit, rows[i].x_su);
         chk(app_class_level, rows[i].x_cls);
         chk(perf_feature_flags, rows[i].feat);
         chk(class_one_ok, rows[i].x_cls >= CLASS_ONE);
      end
      // Frozen while the enable is low
      load_au(10'h010);
      chk(recording_subunit, 4'h8);
      clk_en <= 1'b0;
      load_au(10'h020);
      chk(video_class_au_size, 10'h010);
      clk_en <= 1'b1;
      // Suspension point: load, miss, hit, erase, set free, zero point
      cur_au_base <= 22'h00_0100;
      cur_point <= 22'h00_0123;
      host.issue(CMD_VIDEO, 32'h5000_0000);
      #1;
      chk(suspend_point, 22'h00_0123);
      mem_op(1'b1, 1'b0, 22'h00_0120);
      chk(suspend_point, 22'h00_0123);
      mem_op(1'b1, 1'b0, 22'h00_011F);
      chk(suspend_point, 22'h0);
      host.issue(CMD_VIDEO, 32'h5000_0000);
      #1;
      chk(suspend_point, 22'h00_0123);
      mem_op(1'b0, 1'b1, 22'h00_0100);
      chk(suspend_point, 22'h0);
      host.issue(CMD_VIDEO, 32'h5000_0000);
      #1;
      chk(suspend_point, 22'h00_0123);
      host.issue(CMD_VIDEO, 32'h7000_0000);
      #1;
      chk(suspend_point, 22'h0);
      cur_point <= 22'h0;
      host.issue(CMD_VIDEO, 32'h5000_0000);
      #1;
      chk(suspend_point, 22'h0);
      // Task map with 24 tasks: upper bits stay zero
      task_ev(32'hFFFF_FFFF, 32'h0);
      task_ev(32'h0000_0020, 32'h0000_0021);
      host.status(32'h0000_8000, seen, is_task, data);
      chk(seen, 1'b1);
      chk(is_task, 1'b1);
      chk(data, 32'h00FF_FFFE);
      host.status(32'h0000_7FFF, seen, is_task, data);
      chk(is_task, 1'b0);
      chk(data, 32'hA5A5_5A5A);
      @(posedge core_clk);
      #1;
      chk(resp_valid, 1'b0);
      // Second reset mid-run
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk(video_class_au_size, 10'h000);
      chk(app_class_level, 4'h0);
      chk(resp_data, 32'h0);
      @(posedge core_clk);
      #1;
      chk(app_class_level, 4'h2);
      chk(perf_feature_flags, 8'h10);
      conclude();
   end
endmodule : tb_top
